// [dv/fsrx_fast_serial_port_asserts.sv]
`timescale 1ns/1ps
module fsrx_fast_serial_port_asserts
  import fsrx_pkg::*;
#(
  parameter int MEM_AW = 16
) (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_ack_o,
  input wire logic              serialRxLine,
  input wire logic              clearToSendIn,
  input wire logic              requestToSendOut,
  input wire logic              serialTxLine,
  input wire logic              memWrValid,
  input wire logic              memWrReady,
  input wire logic [MEM_AW-1:0] memWrAddr,
  input wire logic [7:0]        memWrData,
  input wire logic              rxReadyFlag,
  input wire logic              irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic       txPrev_r, txPrev_nxt;
  logic [7:0] txCnt_r, txCnt_nxt;
  // Cycles since the start bit fell
  always_comb begin
    txPrev_nxt = serialTxLine;
    txCnt_nxt = 8'h00;
    if (txCnt_r != 8'h00 && txCnt_r < 8'hFA) txCnt_nxt = txCnt_r + 8'h01;
    else if (txCnt_r == 8'h00 && txPrev_r && !serialTxLine) txCnt_nxt = 8'h01;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txPrev_r <= 1'b1;
      txCnt_r <= 8'h00;
    end else begin
      txPrev_r <= txPrev_nxt;
      txCnt_r <= txCnt_nxt;
    end
  end
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_next; (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");
  property p_reset_idle;
    $rose(rst_b) |-> serialTxLine && !requestToSendOut && !memWrValid && !rxReadyFlag && !irq;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
  // Only before a start bit, cts may drop once the frame runs
  property p_cts_gate;
    (requestToSendOut && serialTxLine && !clearToSendIn && txCnt_r == 8'h00) [*4] |=> serialTxLine;
  endproperty
  a_cts_gate: assert property (p_cts_gate) else $error("start bit while cts low");
  property p_start_cts;
    ($fell(serialTxLine) && requestToSendOut && txCnt_r == 8'h00) |-> $past(clearToSendIn, 3);
  endproperty
  a_start_cts: assert property (p_start_cts) else $error("start bit without cts");
  property p_rts_drop; $fell(requestToSendOut) |-> txCnt_r inside {[8'h45:8'h5B]}; endproperty
  a_rts_drop: assert property (p_rts_drop) else $error("rts not dropped in third data bit");
  property p_rts_early; $rose(requestToSendOut) |-> serialTxLine; endproperty
  a_rts_early: assert property (p_rts_early) else $error("rts rose after start bit");
  property p_mem_hold;
    (memWrValid && !memWrReady) |=> memWrValid && $stable(memWrData) && $stable(memWrAddr);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("memory write dropped while stalled");
  property p_mem_inc; (memWrValid && memWrReady) |=> memWrAddr == $past(memWrAddr) + 1'b1; endproperty
  a_mem_inc: assert property (p_mem_inc) else $error("memory address not advanced");
  property p_rdy_stop; $rose(rxReadyFlag) |-> $past(serialRxLine, 3); endproperty
  a_rdy_stop: assert property (p_rdy_stop) else $error("ready rose without high stop");
endmodule : fsrx_fast_serial_port_asserts

bind fsrx_fast_serial_port fsrx_fast_serial_port_asserts #(.MEM_AW(MEM_AW)) i_fsrx_fast_serial_port_asserts (
  .clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .serialRxLine(serialRxLine), .clearToSendIn(clearToSendIn), .requestToSendOut(requestToSendOut),
  .serialTxLine(serialTxLine), .memWrValid(memWrValid), .memWrReady(memWrReady), .memWrAddr(memWrAddr),
  .memWrData(memWrData), .rxReadyFlag(rxReadyFlag), .irq(irq));

// [dv/fsrx_fast_serial_port_tb_top.sv]
`timescale 1ns/1ps
module fsrx_fast_serial_port_tb_top
  import fsrx_pkg::*;
;
  logic        clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, serialRxLine, clearToSendIn;
  logic        requestToSendOut, serialTxLine, memWrValid, memWrReady, rxReadyFlag, irq;
  logic [5:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] memWrAddr;
  logic [7:0]  memWrData;
  logic [7:0]  rxBytes [3] = '{8'hA5, 8'h3C, 8'h81};
  int          bitCyc [3] = '{23, 22, 24};
  int          err_count, checks_done, n;

  fsrx_fast_serial_port i_fsrx_fast_serial_port (
    .clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .serialRxLine(serialRxLine), .clearToSendIn(clearToSendIn), .requestToSendOut(requestToSendOut),
    .serialTxLine(serialTxLine), .memWrValid(memWrValid), .memWrReady(memWrReady), .memWrAddr(memWrAddr),
    .memWrData(memWrData), .rxReadyFlag(rxReadyFlag), .irq(irq));
  fsrx_remote_model i_fsrx_remote_model (
    .clk(clk), .requestToSendOut(requestToSendOut), .serialRxLine(serialRxLine), .clearToSendIn(clearToSendIn));

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk32
  task automatic chk1(input logic got, input logic exp, input string what);
    chk32({31'h0, got}, {31'h0, exp}, what);
  endtask : chk1
  // Classic cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [3:0] idx, input logic [31:0] wd);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= wd;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic rdchk(input logic [3:0] idx, input logic [31:0] exp, input string what);
    wb(1'b0, idx, 32'h0);
    chk32(rd, exp, what);
  endtask : rdchk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(25 * 20000);
    err_count++;
    tally_and_finish();
  end
  initial begin
    rst_b = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, memWrReady} = 4'h0;
    wb_adr_i = 6'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    err_count = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk1(rxReadyFlag, 1'b0, "ready at reset");
    chk1(irq, 1'b0, "irq at reset");
    rdchk(ADR_CTRL, {28'h0, CTRL_RESET}, "ctrl");
    rdchk(ADR_DIV, {16'h0, DIV_RESET}, "div");
    rdchk(ADR_STATUS, 32'h00000002, "status");
    wb(1'b1, 4'hF, 32'hFFFFFFFF);
    rdchk(4'hF, 32'h0, "unmapped");
    rdchk(ADR_IRQ_CLR, 32'h0, "clear reg");
    $display("test reset done");
    wb(1'b1, ADR_IRQ_EN, 32'h1);
    for (int i = 0; i < 3; i++) i_fsrx_remote_model.send_byte(rxBytes[i], bitCyc[i], 1'b1);
    repeat (4) @(posedge clk);
    chk1(rxReadyFlag, 1'b1, "ready set");
    chk1(irq, 1'b1, "irq raised");
    for (int i = 0; i < 3; i++) rdchk(ADR_RXDATA, {24'h0, rxBytes[i]}, "rx byte");
    chk1(rxReadyFlag, 1'b0, "ready clear");
    wb(1'b1, ADR_IRQ_EN, 32'h0);
    chk1(irq, 1'b0, "irq masked");
    rdchk(ADR_IRQ_STAT, 32'h1, "sticky status");
    wb(1'b1, ADR_IRQ_CLR, 32'h1);
    rdchk(ADR_IRQ_STAT, 32'h0, "status cleared");
    $display("test byte mode done");
    wb(1'b1, ADR_MEM_ADDR, 32'h0100);
    wb(1'b1, ADR_CTRL, 32'h5);
    for (int i = 0; i < 2; i++) begin
      i_fsrx_remote_model.send_byte(rxBytes[i], 23, 1'b1);
      for (n = 0; n < 100 && memWrValid !== 1'b1; n++) @(posedge clk);
      chk1(memWrValid, 1'b1, "mem valid");
      chk32({24'h0, memWrData}, {24'h0, rxBytes[i]}, "mem data");
      chk32({16'h0, memWrAddr}, 32'h0100 + i, "mem addr");
      chk1(rxReadyFlag, 1'b0, "no fifo in block");
      repeat (5) @(posedge clk);
      memWrReady <= 1'b1;
      @(posedge clk);
      memWrReady <= 1'b0;
    end
    $display("test block mode done");
    wb(1'b1, ADR_CTRL, 32'h6);
    i_fsrx_remote_model.ctsDelay = 10;
    wb(1'b1, ADR_TXDATA, 32'h96);
    chk1(requestToSendOut, 1'b1, "rts up");
    chk1(serialTxLine, 1'b1, "held by cts");
    for (n = 0; n < 100 && serialTxLine !== 1'b0; n++) @(posedge clk);
    chk1(n >= 9 && serialTxLine === 1'b0, 1'b1, "start after cts");
    for (n = 0; n < 200 && requestToSendOut === 1'b1; n++) @(posedge clk);
    chk1(n >= 68 && n < 92, 1'b1, "rts drop bit");
    repeat (200) @(posedge clk);
    rdchk(ADR_IRQ_STAT, 32'h9, "tx done and block bytes");
    $display("test handshake done");
    i_fsrx_remote_model.ctsDelay = -1;
    wb(1'b1, ADR_CTRL, 32'h4);
    wb(1'b1, ADR_TXDATA, 32'h3C);
    for (n = 0; n < 20 && serialTxLine !== 1'b0; n++) @(posedge clk);
    chk1(serialTxLine, 1'b0, "start without cts");
    chk1(requestToSendOut, 1'b0, "no rts");
    repeat (240) @(posedge clk);
    $display("test no handshake done");
    wb(1'b1, ADR_IRQ_CLR, 32'hF);
    wb(1'b1, ADR_CTRL, 32'h0);
    i_fsrx_remote_model.send_byte(8'hA5, 23, 1'b1);
    repeat (4) @(posedge clk);
    rdchk(ADR_IRQ_STAT, 32'h0, "rx disabled");
    chk1(rxReadyFlag, 1'b0, "no byte when disabled");
    wb(1'b1, ADR_CTRL, 32'h4);
    i_fsrx_remote_model.send_byte(8'h5A, 23, 1'b0);
    rdchk(ADR_IRQ_STAT, 32'h2, "framing error");
    chk1(rxReadyFlag, 1'b0, "bad frame dropped");
    for (int i = 0; i < 5; i++) i_fsrx_remote_model.send_byte(8'h10 + 8'(i), 23, 1'b1);
    repeat (4) @(posedge clk);
    rdchk(ADR_IRQ_STAT, 32'h7, "overrun");
    for (int i = 0; i < 4; i++) rdchk(ADR_RXDATA, 32'h10 + i, "fifo order");
    chk1(rxReadyFlag, 1'b0, "fifo drained");
    $display("test errors done");
    tally_and_finish();
  end
endmodule : fsrx_fast_serial_port_tb_top

// [dv/fsrx_remote_model.sv]
`timescale 1ns/1ps
module fsrx_remote_model (
  input  wire logic clk,
  input  wire logic requestToSendOut,
  output logic      serialRxLine,
  output logic      clearToSendIn
);
  int ctsDelay = -1;
  int ctsCnt = 0;
  initial begin
    serialRxLine = 1'b1;
    clearToSendIn = 1'b0;
  end
  // One frame, low start, LSB first, high is one, bitCyc clocks a bit
  task automatic send_byte(input logic [7:0] data, input int bitCyc, input logic stopBit);
    logic [9:0] frame;
    frame = {stopBit, data, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serialRxLine <= frame[i];
      repeat (bitCyc) @(posedge clk);
    end
    if (!stopBit) begin
      serialRxLine <= 1'b1;
      repeat (bitCyc) @(posedge clk);
    end
  endtask : send_byte
  // Cts low until rts, raised after ctsDelay, held until rts drops
  always @(posedge clk) begin
    if (!requestToSendOut) begin
      ctsCnt <= 0;
      clearToSendIn <= 1'b0;
    end else if (ctsDelay >= 0 && ctsCnt >= ctsDelay) begin
      clearToSendIn <= 1'b1;
    end else begin
      ctsCnt <= ctsCnt + 1;
    end
  end
endmodule : fsrx_remote_model

// [hdl/fsrx_fast_serial_port.sv]
// Local design decisions: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module fsrx_fast_serial_port
  import fsrx_pkg::*;
#(
  parameter int FIFO_DEPTH = 4,
  parameter int MEM_AW     = 16
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [5:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              serialRxLine,
  input  wire logic              clearToSendIn,
  output logic                   requestToSendOut,
  output logic                   serialTxLine,
  output logic                   memWrValid,
  input  wire logic              memWrReady,
  output logic      [MEM_AW-1:0] memWrAddr,
  output logic      [7:0]        memWrData,
  output logic                   rxReadyFlag,
  output logic                   irq
);
  // Register state
  logic [3:0]        ctrl_r, ctrl_nxt;
  logic [15:0]       div_r, div_nxt;
  logic [EV_W-1:0]   irqStat_r, irqStat_nxt, irqEn_r, irqEn_nxt;
  logic [MEM_AW-1:0] memAddr_r, memAddr_nxt;
  logic              ack_r, ack_nxt;
  logic [31:0]       dat_r, dat_nxt;
  logic              txReq_r, txReq_nxt;
  logic [7:0]        txByte_r, txByte_nxt;
  logic [EV_W-1:0]   events;
  logic              busWr, busRd, wrLow;
  logic [3:0]        regIdx;

  // Receive state
  fsrx_state_t       rxSt_r, rxSt_nxt;
  logic [15:0]       rxCnt_r, rxCnt_nxt;
  logic [2:0]        rxBit_r, rxBit_nxt;
  logic [7:0]        rxSh_r, rxSh_nxt;
  logic              rxIn, rxDone;
  logic              memPend_r, memPend_nxt;
  logic [7:0]        memData_r, memData_nxt;

  // Transmit state
  fstx_state_t       txSt_r, txSt_nxt;
  logic [15:0]       txCnt_r, txCnt_nxt;
  logic [3:0]        txBit_r, txBit_nxt;
  logic [9:0]        txSh_r, txSh_nxt;
  logic              rts_r, rts_nxt;
  logic [1:0]        ctsWait_r, ctsWait_nxt;
  logic              ctsIn;

  logic              fifoWrValid, fifoWrReady, fifoRdValid, fifoRdReady;
  logic [7:0]        fifoRdData;

  fsrx_sync #(.RESET_VAL(1'b1)) uRxSync (
    .clk     (clk),
    .rst_b   (rst_b),
    .asyncIn (serialRxLine),
    .syncOut (rxIn)
  );

  fsrx_sync #(.RESET_VAL(1'b0)) uCtsSync (
    .clk     (clk),
    .rst_b   (rst_b),
    .asyncIn (clearToSendIn),
    .syncOut (ctsIn)
  );

  fsrx_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) uRxFifo (
    .clk     (clk),
    .rst_b   (rst_b),
    .wrValid (fifoWrValid),
    .wrReady (fifoWrReady),
    .wrData  (rxSh_r),
    .rdValid (fifoRdValid),
    .rdReady (fifoRdReady),
    .rdData  (fifoRdData)
  );

  // Bus decode
  assign regIdx   = wb_adr_i[5:2];
  assign busWr    = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
  assign busRd    = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r;
  assign wrLow    = busWr && wb_sel_i[0];
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign fifoRdReady = busRd && (regIdx == ADR_RXDATA);
  assign rxReadyFlag = fifoRdValid;
  assign irq = |(irqStat_r & irqEn_r);
  assign requestToSendOut = rts_r;
  assign serialTxLine = txSh_r[0];
  assign memWrValid = memPend_r;
  assign memWrAddr  = memAddr_r;
  assign memWrData  = memData_r;

  // Receiver: mid-bit sampling; divisor is clocks per bit time
  always_comb begin
    rxSt_nxt    = rxSt_r;
    rxCnt_nxt   = rxCnt_r;
    rxBit_nxt   = rxBit_r;
    rxSh_nxt    = rxSh_r;
    rxDone      = 1'b0;
    events      = '0;
    case (rxSt_r)
      FSRX_IDLE: begin
        if (ctrl_r[CTRL_RX_EN] && !rxIn) begin
          rxSt_nxt  = FSRX_START;
          rxCnt_nxt = {1'b0, div_r[15:1]};
        end
      end
      FSRX_START: begin
        if (rxCnt_r == '0) begin
          if (rxIn) begin
            rxSt_nxt = FSRX_IDLE;
          end else begin
            rxSt_nxt  = FSRX_DATA;
            rxCnt_nxt = div_r - 16'h0001;
            rxBit_nxt = '0;
          end
        end else begin
          rxCnt_nxt = rxCnt_r - 16'h0001;
        end
      end
      FSRX_DATA: begin
        if (rxCnt_r == '0) begin
          rxSh_nxt  = {rxIn, rxSh_r[7:1]};
          rxCnt_nxt = div_r - 16'h0001;
          rxBit_nxt = rxBit_r + 3'h1;
          if (rxBit_r == 3'h7) rxSt_nxt = FSRX_STOP;
        end else begin
          rxCnt_nxt = rxCnt_r - 16'h0001;
        end
      end
      FSRX_STOP: begin
        if (rxCnt_r == '0) begin
          rxSt_nxt = FSRX_IDLE;
          if (rxIn) rxDone = 1'b1;
          else events[EV_FRAMEERR] = 1'b1;
        end else begin
          rxCnt_nxt = rxCnt_r - 16'h0001;
        end
      end
      default: rxSt_nxt = FSRX_IDLE;
    endcase
    if (rxDone) events[EV_RXBYTE] = 1'b1;
    fifoWrValid = rxDone && !ctrl_r[CTRL_BLOCK];
    if (fifoWrValid && !fifoWrReady) events[EV_OVERRUN] = 1'b1;
    memPend_nxt = memPend_r && !memWrReady;
    memData_nxt = memData_r;
    memAddr_nxt = memAddr_r;
    if (memPend_r && memWrReady) memAddr_nxt = memAddr_r + 1'b1;
    if (rxDone && ctrl_r[CTRL_BLOCK]) begin
      if (memPend_r && !memWrReady) begin
        events[EV_OVERRUN] = 1'b1;
      end else begin
        memPend_nxt = 1'b1;
        memData_nxt = rxSh_r;
      end
    end
    if (busWr && (regIdx == ADR_MEM_ADDR)) memAddr_nxt = wb_dat_i[MEM_AW-1:0];
    if (txSt_r == FSTX_SHIFT && txBit_r == 4'h9 && txCnt_r == '0) events[EV_TXDONE] = 1'b1;
  end

  // Transmitter with request/clear-to-send handshake
  always_comb begin
    txSt_nxt    = txSt_r;
    txCnt_nxt   = txCnt_r;
    txBit_nxt   = txBit_r;
    txSh_nxt    = txSh_r;
    rts_nxt     = rts_r;
    ctsWait_nxt = ctsWait_r;
    txReq_nxt   = txReq_r;
    txByte_nxt  = txByte_r;
    if (busWr && (regIdx == ADR_TXDATA) && !txReq_r && wb_sel_i[0]) begin
      txReq_nxt  = 1'b1;
      txByte_nxt = wb_dat_i[7:0];
    end
    case (txSt_r)
      FSTX_IDLE: begin
        if (txReq_r) begin
          txSt_nxt    = FSTX_WAIT;
          rts_nxt     = ctrl_r[CTRL_HSK];
          ctsWait_nxt = 2'(CTS_SETUP_CYC);
        end
      end
      FSTX_WAIT: begin
        if (ctsWait_r != '0) ctsWait_nxt = ctsWait_r - 2'h1;
        if (!ctrl_r[CTRL_HSK] || (ctsWait_r == '0 && ctsIn)) begin
          txSt_nxt  = FSTX_SHIFT;
          txSh_nxt  = {1'b1, txByte_r, 1'b0};
          txCnt_nxt = div_r - 16'h0001;
          txBit_nxt = '0;
          txReq_nxt = 1'b0;
        end
      end
      FSTX_SHIFT: begin
        if (txCnt_r == '0) begin
          txCnt_nxt = div_r - 16'h0001;
          txSh_nxt  = {1'b1, txSh_r[9:1]};
          txBit_nxt = txBit_r + 4'h1;
          if (txBit_r == 4'(RTS_DROP_BIT - 1)) rts_nxt = 1'b0;
          if (txBit_r == 4'h9) txSt_nxt = FSTX_IDLE;
        end else begin
          txCnt_nxt = txCnt_r - 16'h0001;
        end
      end
      default: txSt_nxt = FSTX_IDLE;
    endcase
  end

  // Register file
  always_comb begin
    ctrl_nxt    = ctrl_r;
    div_nxt     = div_r;
    irqEn_nxt   = irqEn_r;
    irqStat_nxt = irqStat_r;
    ack_nxt     = wb_cyc_i && wb_stb_i && !ack_r;
    dat_nxt     = dat_r;
    if (wrLow && regIdx == ADR_CTRL)    ctrl_nxt = wb_dat_i[3:0];
    if (busWr && regIdx == ADR_DIV)     div_nxt  = {wb_sel_i[1] ? wb_dat_i[15:8] : div_r[15:8],
                                                    wb_sel_i[0] ? wb_dat_i[7:0] : div_r[7:0]};
    if (wrLow && regIdx == ADR_IRQ_EN)  irqEn_nxt = wb_dat_i[EV_W-1:0];
    if (wrLow && regIdx == ADR_IRQ_CLR) irqStat_nxt = irqStat_r & ~wb_dat_i[EV_W-1:0];
    irqStat_nxt = irqStat_nxt | events;
    if (busRd) begin
      case (regIdx)
        ADR_CTRL:     dat_nxt = {28'h0000000, ctrl_r};
        ADR_DIV:      dat_nxt = {16'h0000, div_r};
        ADR_RXDATA:   dat_nxt = {24'h000000, fifoRdValid ? fifoRdData : 8'h00};
        ADR_STATUS:   dat_nxt = {26'h0000000, memPend_r, txReq_r, rts_r, ctsIn, rxIn, fifoRdValid};
        ADR_IRQ_STAT: dat_nxt = {28'h0000000, irqStat_r};
        ADR_IRQ_EN:   dat_nxt = {28'h0000000, irqEn_r};
        ADR_MEM_ADDR: dat_nxt = {{(32-MEM_AW){1'b0}}, memAddr_r};
        default:      dat_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r    <= CTRL_RESET;
      div_r     <= DIV_RESET;
      irqStat_r <= '0;
      irqEn_r   <= '0;
      memAddr_r <= '0;
      ack_r     <= 1'b0;
      dat_r     <= '0;
      txReq_r   <= 1'b0;
      txByte_r  <= '0;
      rxSt_r    <= FSRX_IDLE;
      rxCnt_r   <= '0;
      rxBit_r   <= '0;
      rxSh_r    <= '0;
      memPend_r <= 1'b0;
      memData_r <= '0;
      txSt_r    <= FSTX_IDLE;
      txCnt_r   <= '0;
      txBit_r   <= '0;
      txSh_r    <= 10'h3FF;
      rts_r     <= 1'b0;
      ctsWait_r <= '0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      div_r     <= div_nxt;
      irqStat_r <= irqStat_nxt;
      irqEn_r   <= irqEn_nxt;
      memAddr_r <= memAddr_nxt;
      ack_r     <= ack_nxt;
      dat_r     <= dat_nxt;
      txReq_r   <= txReq_nxt;
      txByte_r  <= txByte_nxt;
      rxSt_r    <= rxSt_nxt;
      rxCnt_r   <= rxCnt_nxt;
      rxBit_r   <= rxBit_nxt;
      rxSh_r    <= rxSh_nxt;
      memPend_r <= memPend_nxt;
      memData_r <= memData_nxt;
      txSt_r    <= txSt_nxt;
      txCnt_r   <= txCnt_nxt;
      txBit_r   <= txBit_nxt;
      txSh_r    <= txSh_nxt;
      rts_r     <= rts_nxt;
      ctsWait_r <= ctsWait_nxt;
    end
  end
endmodule : fsrx_fast_serial_port

// [hdl/fsrx_fifo.sv]
`timescale 1ns/1ps
module fsrx_fifo
  import fsrx_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             wrValid,
  output logic                  wrReady,
  input  wire logic [WIDTH-1:0] wrData,
  output logic                  rdValid,
  input  wire logic             rdReady,
  output logic      [WIDTH-1:0] rdData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0]    wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [AW:0]      count_r, count_nxt;
  logic             doWr, doRd;

  assign wrReady = (count_r != (AW+1)'(DEPTH));
  assign rdValid = (count_r != '0);
  assign rdData  = mem_r[rdPtr_r];

  always_comb begin
    doWr      = wrValid && wrReady;
    doRd      = rdValid && rdReady;
    mem_nxt   = mem_r;
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    if (doWr) begin
      mem_nxt[wrPtr_r] = wrData;
      wrPtr_nxt        = (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
    end
    if (doRd) begin
      rdPtr_nxt = (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
    end
    count_nxt = count_r + (AW+1)'(doWr) - (AW+1)'(doRd);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) mem_r[i] <= '0;
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      mem_r   <= mem_nxt;
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
    end
  end
endmodule : fsrx_fifo

// [hdl/fsrx_sync.sv]
`timescale 1ns/1ps
module fsrx_sync
  import fsrx_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic stage1_r, stage2_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_r <= RESET_VAL;
      stage2_r <= RESET_VAL;
    end else begin
      stage1_r <= asyncIn;
      stage2_r <= stage1_r;
    end
  end
  assign syncOut = stage2_r;
endmodule : fsrx_sync

// [include/fsrx_pkg.sv]
package fsrx_pkg;
  localparam logic [3:0]  ADR_CTRL      = 4'h0;
  localparam logic [3:0]  ADR_DIV       = 4'h1;
  localparam logic [3:0]  ADR_RXDATA    = 4'h2;
  localparam logic [3:0]  ADR_TXDATA    = 4'h3;
  localparam logic [3:0]  ADR_STATUS    = 4'h4;
  localparam logic [3:0]  ADR_IRQ_STAT  = 4'h5;
  localparam logic [3:0]  ADR_IRQ_EN    = 4'h6;
  localparam logic [3:0]  ADR_IRQ_CLR   = 4'h7;
  localparam logic [3:0]  ADR_MEM_ADDR  = 4'h8;
  localparam int          CTRL_BLOCK    = 0;
  localparam int          CTRL_HSK      = 1;
  localparam int          CTRL_RX_EN    = 2;
  localparam int          EV_RXBYTE     = 0;
  localparam int          EV_FRAMEERR   = 1;
  localparam int          EV_OVERRUN    = 2;
  localparam int          EV_TXDONE     = 3;
  localparam int          EV_W          = 4;
  localparam logic [15:0] DIV_RESET     = 16'h0017;
  localparam logic [3:0]  CTRL_RESET    = 4'h4;
  localparam int          RTS_DROP_BIT  = 3;
  localparam int          CTS_SETUP_PS  = 31250; // 1.5 periods of 48 MHz
  localparam int          CLK_PERIOD_PS = 25000;
  localparam int          CTS_SETUP_CYC = (CTS_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  typedef enum logic [1:0] {FSRX_IDLE, FSRX_START, FSRX_DATA, FSRX_STOP} fsrx_state_t;
  typedef enum logic [1:0] {FSTX_IDLE, FSTX_WAIT, FSTX_SHIFT} fstx_state_t;
endpackage : fsrx_pkg
